// ### core/spw_edge_sync.sv
module spw_edge_sync (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [8:0] pins,
    output logic [8:0] level,
    output logic [8:0] fall
);

    // ==================================================
    // three stage sync, change accepted once stages two and three agree
    spw_pkg::spw_sync_t cur;
    spw_pkg::spw_sync_t next_st;

    always_comb begin
        next_st = cur;
        next_st.s1 = pins;
        next_st.s2 = cur.s1;
        next_st.s3 = cur.s2;
        next_st.level = (cur.s2 & cur.s3) | (cur.level & (cur.s2 | cur.s3));
        next_st.fall = cur.level & ~next_st.level;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cur.s1 <= spw_pkg::SYNC_RESET;
            cur.s2 <= spw_pkg::SYNC_RESET;
            cur.s3 <= spw_pkg::SYNC_RESET;
            cur.level <= spw_pkg::SYNC_RESET;
            cur.fall <= 9'h000;
        end else begin
            cur <= next_st;
        end
    end

    assign level = cur.level;
    assign fall = cur.fall;

endmodule

// ### core/spw_pkg.sv
package spw_pkg;

    // ==================================================
    // apb carrier
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } spw_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } spw_apb_rsp_t;

    // ==================================================
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_EN1 = 10'h0b0;
    localparam logic [9:0] IDX_EN2 = 10'h0b1;
    localparam logic [9:0] IDX_ST1 = 10'h0b2;
    localparam logic [9:0] IDX_ST2 = 10'h0b3;
    localparam logic [9:0] IDX_MASK1 = 10'h0b4;
    localparam logic [9:0] IDX_MASK2 = 10'h0b5;

    // ==================================================
    // reset values and field layouts
    localparam logic [7:0] RST_EN1 = 8'h00;
    localparam logic [7:0] RST_EN2 = 8'h80;
    localparam logic [7:0] RST_ST = 8'h00;
    localparam logic [7:0] RST_MASK = 8'h00;
    localparam logic [7:0] EN2_WRITABLE = 8'hab;
    localparam logic [7:0] ST1_LATCHED = 8'hcf;
    localparam logic [7:0] ST2_USED = 8'h2b;

    // first layout, shared by enable one, status one, mask one
    localparam int B1_RING_A = 0;
    localparam int B1_RING_B = 1;
    localparam int B1_KBD = 2;
    localparam int B1_MOUSE = 3;
    localparam int B1_GROUP_A = 4;
    localparam int B1_GROUP_B = 5;
    localparam int B1_IR = 6;
    localparam int B1_ALARM = 7;

    // second layout, shared by enable two, status two, mask two
    localparam int B2_RX_A = 0;
    localparam int B2_RX_B = 1;
    localparam int B2_RING = 3;
    localparam int B2_CIR = 5;
    localparam int B2_SOFT_OFF = 7;

    // ==================================================
    // pin synchroniser
    localparam int NUM_PINS = 9;
    localparam int P_RING_A = 0;
    localparam int P_RING_B = 1;
    localparam int P_KBD = 2;
    localparam int P_MOUSE = 3;
    localparam int P_IR = 4;
    localparam int P_RX_A = 5;
    localparam int P_RX_B = 6;
    localparam int P_RING = 7;
    localparam int P_PGOOD = 8;
    // wake pins idle high, power good idles low
    localparam logic [8:0] SYNC_RESET = 9'h0ff;

    typedef struct packed {
        logic [8:0] s1;
        logic [8:0] s2;
        logic [8:0] s3;
        logic [8:0] level;
        logic [8:0] fall;
    } spw_sync_t;

    typedef struct packed {
        logic [7:0] en1;
        logic [7:0] en2;
        logic [7:0] st1;
        logic [7:0] st2;
        logic [7:0] mask1;
        logic [7:0] mask2;
        logic [31:0] prdata;
        logic req;
    } spw_state_t;

endpackage

// ### core/spw_wake_events.sv
// Summary of operation
// RULE1: each set bit of enable one lets its source request power, a clear bit blocks it.
// RULE2: enable one bits 0..3 are ring a, ring b, keyboard clock and mouse clock.
// RULE3: enable one bits 4..7 are group int a, group int b, ir receive and rtc alarm.
// RULE4: enable two bits 0 and 1 are serial rx a and b; bits 2, 4 and 6 read zero.
// RULE5: enable two bit 3 lets the ring input pin request power.
// RULE6: enable two bit 5 lets a consumer ir wake event request power.
// RULE7: enable two bit 7 is the soft off enable and resets to one, value 0x80.
// RULE8: status one shows one per source that fired since last cleared.
// RULE9: status one bits 0,1,2,3,6 latch falling edges of their pins.
// RULE10: latched bits of status one clear when software reads it.
// RULE11: status one bit 7 latches the rtc alarm and clears on read.
// RULE12: status one bits 4 and 5 follow the group ints live, reads leave them.
// RULE13: status two latches enabled rx falls, ring and ir events, cleared on read.
// RULE14: an enabled event drives the power request low until power is good.
// RULE15: enables and status reset only with the battery domain reset.
module spw_wake_events (
    input wire logic mclk,
    input wire logic reset_n,
    input wire spw_pkg::spw_apb_req_t apb_req,
    output spw_pkg::spw_apb_rsp_t apb_rsp,
    input wire logic ring_a_pin,
    input wire logic ring_b_pin,
    input wire logic kbd_clock_pin,
    input wire logic mouse_clock_pin,
    input wire logic ir_receive_pin,
    input wire logic serial_rx_a,
    input wire logic serial_rx_b,
    input wire logic ring_input_n,
    input wire logic power_good,
    input wire logic group_int_a,
    input wire logic group_int_b,
    input wire logic rtc_alarm,
    input wire logic consumer_ir_event,
    output logic power_on_request_n,
    output logic irq
);

    // ==================================================
    // address decode
    function automatic logic [5:0] reg_sel(input logic [11:0] addr);
        logic [9:0] idx;
        idx = addr[11:2];
        reg_sel = 6'h00;
        if (addr[1:0] == 2'h0) begin
            reg_sel[0] = (idx == spw_pkg::IDX_EN1);
            reg_sel[1] = (idx == spw_pkg::IDX_EN2);
            reg_sel[2] = (idx == spw_pkg::IDX_ST1);
            reg_sel[3] = (idx == spw_pkg::IDX_ST2);
            reg_sel[4] = (idx == spw_pkg::IDX_MASK1);
            reg_sel[5] = (idx == spw_pkg::IDX_MASK2);
        end
    endfunction

    // ==================================================
    // pin synchronisers
    logic [8:0] pins;
    logic [8:0] pin_level;
    logic [8:0] pin_fall;

    always_comb begin
        pins = spw_pkg::SYNC_RESET;
        pins[spw_pkg::P_RING_A] = ring_a_pin;
        pins[spw_pkg::P_RING_B] = ring_b_pin;
        pins[spw_pkg::P_KBD] = kbd_clock_pin;
        pins[spw_pkg::P_MOUSE] = mouse_clock_pin;
        pins[spw_pkg::P_IR] = ir_receive_pin;
        pins[spw_pkg::P_RX_A] = serial_rx_a;
        pins[spw_pkg::P_RX_B] = serial_rx_b;
        pins[spw_pkg::P_RING] = ring_input_n;
        pins[spw_pkg::P_PGOOD] = power_good;
    end

    spw_edge_sync u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .pins(pins),
        .level(pin_level),
        .fall(pin_fall)
    );

    logic ring_a_event;
    logic ring_b_event;
    logic kbd_clock_event;
    logic mouse_clock_event;
    logic ir_receive_event;
    logic ring_input_event;
    logic pg_level;

    assign ring_a_event = pin_fall[spw_pkg::P_RING_A];
    assign ring_b_event = pin_fall[spw_pkg::P_RING_B];
    assign kbd_clock_event = pin_fall[spw_pkg::P_KBD];
    assign mouse_clock_event = pin_fall[spw_pkg::P_MOUSE];
    assign ir_receive_event = pin_fall[spw_pkg::P_IR];
    assign ring_input_event = pin_fall[spw_pkg::P_RING];
    assign pg_level = pin_level[spw_pkg::P_PGOOD];

    // ==================================================
    // state
    spw_pkg::spw_state_t cur;
    spw_pkg::spw_state_t next_st;

    logic setup_ph;
    logic access_ph;
    logic [5:0] sel;
    logic [7:0] set1;
    logic [7:0] set2;
    logic [7:0] st1_view;
    logic [7:0] clr1;
    logic [7:0] clr2;
    logic [7:0] rd_byte;
    logic wake_any;

    assign setup_ph = apb_req.psel && !apb_req.penable;
    assign access_ph = apb_req.psel && apb_req.penable;
    assign sel = reg_sel(apb_req.paddr);

    // live group bits sit beside the latched ones
    always_comb begin
        st1_view = cur.st1;
        st1_view[spw_pkg::B1_GROUP_A] = group_int_a; // RULE12
        st1_view[spw_pkg::B1_GROUP_B] = group_int_b; // RULE12
    end

    // ==================================================
    // event capture
    always_comb begin
        set1 = 8'h00;
        set1[spw_pkg::B1_RING_A] = ring_a_event; // RULE9
        set1[spw_pkg::B1_RING_B] = ring_b_event; // RULE9
        set1[spw_pkg::B1_KBD] = kbd_clock_event; // RULE9
        set1[spw_pkg::B1_MOUSE] = mouse_clock_event; // RULE9
        set1[spw_pkg::B1_IR] = ir_receive_event; // RULE9
        set1[spw_pkg::B1_ALARM] = rtc_alarm; // RULE11
        set2 = 8'h00;
        set2[spw_pkg::B2_RX_A] = pin_fall[spw_pkg::P_RX_A];
        set2[spw_pkg::B2_RX_B] = pin_fall[spw_pkg::P_RX_B];
        set2[spw_pkg::B2_RING] = ring_input_event;
        set2[spw_pkg::B2_CIR] = consumer_ir_event;
        set2 = set2 & cur.en2 & spw_pkg::ST2_USED; // RULE13
    end

    // clear only the bits that were returned, so nothing set after setup is lost
    always_comb begin
        clr1 = 8'h00;
        clr2 = 8'h00;
        if (access_ph && !apb_req.pwrite && sel[2]) begin
            clr1 = cur.prdata[7:0] & spw_pkg::ST1_LATCHED; // RULE10 RULE11
        end
        if (access_ph && !apb_req.pwrite && sel[3]) begin
            clr2 = cur.prdata[7:0] & spw_pkg::ST2_USED; // RULE13
        end
    end

    // ==================================================
    // wake request
    always_comb begin
        wake_any = |(st1_view & cur.en1); // RULE1 RULE2 RULE3
        wake_any = wake_any | (|(cur.st2 & cur.en2 & spw_pkg::ST2_USED)); // RULE4 RULE5 RULE6
    end

    // ==================================================
    // read mux
    always_comb begin
        rd_byte = 8'h00;
        case (1'b1)
            sel[0]: rd_byte = cur.en1;
            sel[1]: rd_byte = cur.en2;
            sel[2]: rd_byte = st1_view; // RULE8
            sel[3]: rd_byte = cur.st2;
            sel[4]: rd_byte = cur.mask1;
            sel[5]: rd_byte = cur.mask2;
            default: rd_byte = 8'h00;
        endcase
    end

    // ==================================================
    // next state
    always_comb begin
        next_st = cur;
        // set wins over a read clear in the same cycle
        next_st.st1 = ((cur.st1 & ~clr1) | set1) & spw_pkg::ST1_LATCHED; // RULE9 RULE10
        next_st.st2 = (cur.st2 & ~clr2) | set2; // RULE13
        if (setup_ph && !apb_req.pwrite) begin
            next_st.prdata = {24'h000000, rd_byte};
        end
        if (access_ph && apb_req.pwrite) begin
            if (sel[0]) begin
                next_st.en1 = apb_req.pwdata[7:0];
            end
            if (sel[1]) begin
                next_st.en2 = apb_req.pwdata[7:0] & spw_pkg::EN2_WRITABLE; // RULE4
            end
            if (sel[4]) begin
                next_st.mask1 = apb_req.pwdata[7:0];
            end
            if (sel[5]) begin
                next_st.mask2 = apb_req.pwdata[7:0] & spw_pkg::ST2_USED;
            end
        end
        // request holds until the supply reports good
        next_st.req = wake_any || (cur.req && !pg_level); // RULE14
    end

    // reset_n is the battery domain reset, main power loss leaves it high
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cur.en1 <= spw_pkg::RST_EN1; // RULE15
            cur.en2 <= spw_pkg::RST_EN2; // RULE7 RULE15
            cur.st1 <= spw_pkg::RST_ST; // RULE15
            cur.st2 <= spw_pkg::RST_ST; // RULE15
            cur.mask1 <= spw_pkg::RST_MASK;
            cur.mask2 <= spw_pkg::RST_MASK;
            cur.prdata <= 32'h00000000;
            cur.req <= 1'b0;
        end else begin
            cur <= next_st;
        end
    end

    // ==================================================
    // outputs
    assign power_on_request_n = !cur.req; // RULE14
    assign irq = (|(st1_view & cur.mask1)) || (|(cur.st2 & cur.mask2));
    assign apb_rsp.prdata = cur.prdata;
    assign apb_rsp.pready = 1'b1;
    assign apb_rsp.pslverr = access_ph && (sel == 6'h00);

    // ==================================================
    // assertions
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    logic rd_st1;
    logic sel_st1_setup;
    assign rd_st1 = access_ph && !apb_req.pwrite && sel[2];
    assign sel_st1_setup = setup_ph && !apb_req.pwrite && sel[2];
    logic rd_st2;
    assign rd_st2 = access_ph && !apb_req.pwrite && sel[3];

    a_soft_off_reset: assert property ( // RULE7
        $rose(reset_n) |-> cur.en2 == spw_pkg::RST_EN2)
        else $error("enable two not 0x80 after reset");

    a_en_blocks_wake: assert property ( // RULE1
        (cur.en1 == 8'h00) && ((cur.en2 & spw_pkg::ST2_USED) == 8'h00) && (pg_level || !cur.req)
        |=> power_on_request_n)
        else $error("power request with every source disabled");

    a_mouse_wake_path: assert property ( // RULE2
        mouse_clock_event && cur.en1[spw_pkg::B1_MOUSE] |=> ##1 !power_on_request_n)
        else $error("mouse clock event did not request power");

    a_group_wake_path: assert property ( // RULE3
        group_int_a && cur.en1[spw_pkg::B1_GROUP_A] |=> !power_on_request_n)
        else $error("group int a did not request power");

    a_reserved_zero: assert property ( // RULE4
        (cur.en2 & ~spw_pkg::EN2_WRITABLE) == 8'h00)
        else $error("reserved enable two bits set");

    a_ring_gated: assert property ( // RULE5
        ring_input_event && !cur.en2[spw_pkg::B2_RING] && !cur.st2[spw_pkg::B2_RING]
        |=> !cur.st2[spw_pkg::B2_RING])
        else $error("disabled ring input latched");

    a_cir_latch: assert property ( // RULE6
        consumer_ir_event && cur.en2[spw_pkg::B2_CIR] |=> cur.st2[spw_pkg::B2_CIR])
        else $error("consumer ir event not latched");

    a_edge_latch: assert property ( // RULE9
        ring_a_event |=> cur.st1[spw_pkg::B1_RING_A])
        else $error("ring a fall not latched");

    a_read_clears: assert property ( // RULE10
        rd_st1 && ((set1 & cur.prdata[7:0]) == 8'h00)
        |=> (cur.st1 & $past(cur.prdata[7:0])) == 8'h00)
        else $error("status one read did not clear");

    a_alarm_latch: assert property ( // RULE11
        rtc_alarm |=> cur.st1[spw_pkg::B1_ALARM])
        else $error("alarm not latched");

    a_live_group: assert property ( // RULE12
        sel_st1_setup |=> cur.prdata[5:4] == $past({group_int_b, group_int_a}))
        else $error("group bits not live in read");

    a_req_holds: assert property ( // RULE14
        !power_on_request_n && !pg_level |=> !power_on_request_n)
        else $error("power request dropped before power good");

    a_ir_wake_path: assert property ( // RULE3
        ir_receive_event && cur.en1[spw_pkg::B1_IR] |=> ##1 !power_on_request_n)
        else $error("ir receive event did not request power");

    a_alarm_wake_path: assert property ( // RULE3
        rtc_alarm && cur.en1[spw_pkg::B1_ALARM] |=> ##1 !power_on_request_n)
        else $error("alarm did not request power");

    a_kbd_latch: assert property ( // RULE9
        kbd_clock_event |=> cur.st1[spw_pkg::B1_KBD])
        else $error("keyboard clock fall not latched");

    a_rx_a_latch: assert property ( // RULE13
        pin_fall[spw_pkg::P_RX_A] && cur.en2[spw_pkg::B2_RX_A] |=> cur.st2[spw_pkg::B2_RX_A])
        else $error("serial rx a fall not latched");

    a_rx_b_latch: assert property ( // RULE13
        pin_fall[spw_pkg::P_RX_B] && cur.en2[spw_pkg::B2_RX_B] |=> cur.st2[spw_pkg::B2_RX_B])
        else $error("serial rx b fall not latched");

    a_ring_wake_path: assert property ( // RULE5
        cur.st2[spw_pkg::B2_RING] && cur.en2[spw_pkg::B2_RING] |=> !power_on_request_n)
        else $error("ring input status did not request power");

    a_cir_wake_path: assert property ( // RULE6
        cur.st2[spw_pkg::B2_CIR] && cur.en2[spw_pkg::B2_CIR] |=> !power_on_request_n)
        else $error("consumer ir status did not request power");

    a_status_two_clear: assert property ( // RULE13
        rd_st2 && ((set2 & cur.prdata[7:0]) == 8'h00)
        |=> (cur.st2 & $past(cur.prdata[7:0])) == 8'h00)
        else $error("status two read did not clear");

    a_status_write_ignored: assert property ( // RULE8
        access_ph && apb_req.pwrite && sel[2] && (set1 == 8'h00) |=> cur.st1 == $past(cur.st1))
        else $error("status one changed by a write");

    a_enable_one_write: assert property ( // RULE1
        access_ph && apb_req.pwrite && sel[0] |=> cur.en1 == $past(apb_req.pwdata[7:0]))
        else $error("enable one write lost");

    a_enable_two_write: assert property ( // RULE4
        access_ph && apb_req.pwrite && sel[1]
        |=> cur.en2 == ($past(apb_req.pwdata[7:0]) & spw_pkg::EN2_WRITABLE))
        else $error("enable two write wrong");

    a_power_release: assert property ( // RULE14
        !wake_any && pg_level |=> power_on_request_n)
        else $error("power request kept after power good");

    c_ring_wake: cover property (cur.st2[spw_pkg::B2_RING] && cur.en2[spw_pkg::B2_RING]);
    c_status_read: cover property (rd_st1 && cur.prdata[7:0] != 8'h00);
    c_power_request: cover property ($fell(power_on_request_n));
    c_bad_address: cover property (apb_rsp.pslverr);
    c_irq_raised: cover property ($rose(irq));

endmodule

// ### sim/spw_wake_events_bench.sv
`define CHK(got, want) begin samples_checked++; if ((got) !== (want)) begin errors++; \
    $display("Error at %0t: got %h want %h", $time, got, want); end end

module spw_wake_events_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    spw_pkg::spw_apb_req_t req = '0;
    spw_pkg::spw_apb_rsp_t rsp;
    logic [7:0] fire = '0;
    logic [7:0] pins;
    logic slow = 1'b0;
    logic [1:0] grp = '0;
    logic alarm = 1'b0;
    logic cir = 1'b0;
    logic power_good;
    logic req_n;
    logic irq;
    int errors = 0;
    int samples_checked = 0;
    int seed = 32'h0530;
    int k;
    int s;
    int g;
    int b;
    logic two;
    logic [7:0] en1;
    logic [7:0] en2;
    logic [7:0] st1 = '0;
    logic [7:0] st2 = '0;
    logic [7:0] m1;
    logic [7:0] m2;
    logic [31:0] rd;
    logic err;
    // pins 0..4 land in status one, 5..7 and the ir event in status two
    int src_bit[10] = '{0, 1, 2, 3, 6, 0, 1, 3, 7, 5};

    always #5 mclk = ~mclk;

    spw_wake_events dut (.mclk(mclk), .reset_n(reset_n), .apb_req(req), .apb_rsp(rsp),
        .ring_a_pin(pins[0]), .ring_b_pin(pins[1]), .kbd_clock_pin(pins[2]),
        .mouse_clock_pin(pins[3]), .ir_receive_pin(pins[4]), .serial_rx_a(pins[5]),
        .serial_rx_b(pins[6]), .ring_input_n(pins[7]), .power_good(power_good),
        .group_int_a(grp[0]), .group_int_b(grp[1]), .rtc_alarm(alarm),
        .consumer_ir_event(cir), .power_on_request_n(req_n), .irq(irq));

    spw_wake_partner supply (.mclk(mclk), .reset_n(reset_n), .power_on_request_n(req_n),
        .slow(slow), .fire(fire), .pins(pins), .power_good(power_good));

    // ==================================================
    // closing report
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ==================================================
    // apb master, entered just after a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
        int n;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= wr;
        req.paddr <= a;
        req.pwdata <= {24'h0, wd};
        @(posedge mclk);
        req.penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (rsp.pready === 1'b1) break;
        end
        if (n == 20) begin
            errors++;
            summarize();
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        // one idle edge so back to back calls never drive psel twice in a step
        @(posedge mclk);
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge mclk);
    endtask

    // ==================================================
    // main sequence
    initial begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        for (k = 0; k < 6; k++) begin
            apb(1'b0, 12'h2c0 + 12'(4 * k), 8'h00);
            `CHK(rd, {24'h0, (k == 1) ? 8'h80 : 8'h00})
        end
        apb(1'b0, 12'h2d8, 8'h00);
        `CHK({err, rd}, 33'h1_0000_0000)
        apb(1'b1, 12'h2c1, 8'hff);
        `CHK(err, 1'b1)
        apb(1'b1, 12'h2c8, 8'hff);
        apb(1'b0, 12'h2c8, 8'h00);
        `CHK(rd, 32'h0)
        for (k = 0; k < 4; k++) begin
            en1 = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
            en2 = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : 8'($random(seed));
            m1 = (k == 0) ? 8'hff : 8'($random(seed));
            m2 = (k == 0) ? 8'h2b : 8'($random(seed)) & 8'h2b;
            slow <= k[0];
            apb(1'b1, 12'h2c0, en1);
            apb(1'b1, 12'h2c4, en2);
            apb(1'b1, 12'h2d0, m1);
            apb(1'b1, 12'h2d4, m2);
            en2 = en2 & 8'hab;
            apb(1'b0, 12'h2c4, 8'h00);
            `CHK(rd, {24'h0, en2})
            apb(1'b0, 12'h2d0, 8'h00);
            `CHK(rd, {24'h0, m1})
            apb(1'b0, 12'h2d4, 8'h00);
            `CHK(rd, {24'h0, m2})
            for (s = 0; s < 10; s++) begin
                b = src_bit[s];
                two = (s inside {5, 6, 7, 9});
                if (s < 8) begin
                    fire[s] <= 1'b1;
                end else if (s == 8) begin
                    alarm <= 1'b1;
                end else begin
                    cir <= 1'b1;
                end
                @(posedge mclk);
                fire <= '0;
                alarm <= 1'b0;
                cir <= 1'b0;
                tick(10);
                if (!two) begin
                    st1[b] = 1'b1;
                end else if (en2[b]) begin
                    st2[b] = 1'b1;
                end
                `CHK(irq, |{st1 & m1, st2 & m2})
                `CHK(req_n, ~|{st1 & en1, st2 & en2})
                apb(1'b0, 12'h2c8, 8'h00);
                `CHK(rd, {24'h0, st1})
                st1 = '0;
                apb(1'b0, 12'h2cc, 8'h00);
                `CHK(rd, {24'h0, st2})
                st2 = '0;
                tick(16);
                `CHK(req_n, 1'b1)
            end
        end
        en1 = 8'h10;
        apb(1'b1, 12'h2c0, en1);
        for (g = 0; g < 2; g++) begin
            grp[g] <= 1'b1;
            tick(3);
            repeat (2) begin
                apb(1'b0, 12'h2c8, 8'h00);
                `CHK(rd, 32'h10 << g)
            end
            `CHK(req_n, g != 0)
            `CHK(irq, m1[4 + g])
            grp[g] <= 1'b0;
            tick(16);
            apb(1'b0, 12'h2c8, 8'h00);
            `CHK(rd, 32'h0)
        end
        // battery reset in mid run brings the enables back to their reset values
        reset_n <= 1'b0;
        tick(2);
        reset_n <= 1'b1;
        tick(1);
        apb(1'b0, 12'h2c0, 8'h00);
        `CHK(rd, 32'h0)
        apb(1'b0, 12'h2c4, 8'h00);
        `CHK(rd, 32'h80)
        summarize();
    end
endmodule

// ### sim/spw_wake_partner.sv
module spw_wake_partner (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic power_on_request_n,
    input wire logic slow,
    input wire logic [7:0] fire,
    output logic [7:0] pins,
    output logic power_good
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0][2:0] cnt;
    logic [5:0] pg_pipe;
    // ==================================================
    // wake pins: pulled up, each fire gives a 4 cycle low pulse
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= '0;
            pins <= 8'hff;
            pg_pipe <= '0;
        end else begin
            pg_pipe <= {pg_pipe[4:0], ~power_on_request_n};
            for (int i = 0; i < 8; i++) begin
                if (fire[i]) begin
                    cnt[i] <= 3'h4;
                    pins[i] <= 1'b0;
                end else if (cnt[i] > 3'h1) begin
                    cnt[i] <= cnt[i] - 3'h1;
                end else begin
                    cnt[i] <= 3'h0;
                    pins[i] <= 1'b1;
                end
            end
        end
    end
    // ==================================================
    // supply: power follows the request, a slow supply takes longer either way
    assign power_good = slow ? pg_pipe[5] : pg_pipe[1];
endmodule
